// [src/fsk_tx_map.svh]
`ifndef FSK_TX_MAP_SVH
`define FSK_TX_MAP_SVH

// System clock and sample tick
`define FSK_CLK_HZ 50000000
`define FSK_TICK_HZ 1000000

// Tones in hertz
`define FSK_MARK_HZ 131250
`define FSK_SPACE_HZ 143750

// Wave lookup and phase position
`define FSK_TABLE_LEN 4096
`define FSK_WRAP_LIMIT 4095
`define FSK_INDEX_BITS 12
`define FSK_PHASE_INT_BITS 13
`define FSK_PHASE_FRAC 16

// Bit timing and packet frame
`define FSK_BIT_PERIOD_NS 5120000
`define FSK_PACKET_BITS 33
`define FSK_WORD_BITS 11
`define FSK_FRAME_BITS 209
`define FSK_CYCLE_BITS 8

// Code words, first chip in the top bit, 1 = mark
`define FSK_CODE_ONE 11'h0ED
`define FSK_CODE_ZERO 11'h712

// DAC sample words
`define FSK_SPI_BITS 10
`define FSK_SAMPLE_MID 10'h200
`define FSK_AMP_MAX 10'h1FF

// Sample buffers
`define FSK_BUF_DEPTH 16

`endif

// [src/fsk_tx_pkg.sv]
`include "fsk_tx_map.svh"

package fsk_tx_pkg;

  typedef logic [`FSK_SPI_BITS-1:0] sample_t;
  typedef logic [`FSK_CYCLE_BITS-1:0] cycle_t;
  typedef logic [`FSK_PHASE_INT_BITS+`FSK_PHASE_FRAC-1:0] phase_t;

  typedef enum logic {
    SHIFT_IDLE,
    SHIFT_RUN
  } shift_state_e;

endpackage

// [src/dac_sample_shifter.sv]
`include "fsk_tx_map.svh"

// Sends one DAC sample, top bit first; data changes on the falling clock edge
module dac_sample_shifter (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Sample request
  input wire logic start_in,
  input wire fsk_tx_pkg::sample_t data_in,
  output logic busy_out,
  // Serial pins
  output logic sclk_out,
  output logic mosi_out,
  output logic cs_b_out
);
  import fsk_tx_pkg::*;

  localparam int WORD_BITS = `FSK_SPI_BITS;
  localparam int HALF_BITS = $clog2(2 * WORD_BITS);
  localparam logic [HALF_BITS-1:0] LAST_HALF = HALF_BITS'(2 * WORD_BITS - 1);

  shift_state_e state_q, state_d;
  logic [HALF_BITS-1:0] half_q, half_d;
  sample_t shift_q, shift_d;
  logic sclk_q, sclk_d;
  logic cs_b_q, cs_b_d;

  always_comb begin
    state_d = state_q;
    half_d = half_q;
    shift_d = shift_q;
    sclk_d = sclk_q;
    cs_b_d = cs_b_q;
    case (state_q)
      SHIFT_IDLE: begin
        if (start_in) begin
          state_d = SHIFT_RUN;
          shift_d = data_in;
          half_d = '0;
          cs_b_d = 1'b0;
        end
      end
      SHIFT_RUN: begin
        sclk_d = ~sclk_q;
        if (sclk_q) begin
          shift_d = {shift_q[WORD_BITS-2:0], 1'b0};
        end
        if (half_q == LAST_HALF) begin
          state_d = SHIFT_IDLE;
          sclk_d = 1'b0;
          cs_b_d = 1'b1;
        end else begin
          half_d = half_q + 1'b1;
        end
      end
      default: begin
        state_d = SHIFT_IDLE;
        cs_b_d = 1'b1;
        sclk_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= SHIFT_IDLE;
      half_q <= '0;
      shift_q <= '0;
      sclk_q <= 1'b0;
      cs_b_q <= 1'b1;
    end else begin
      state_q <= state_d;
      half_q <= half_d;
      shift_q <= shift_d;
      sclk_q <= sclk_d;
      cs_b_q <= cs_b_d;
    end
  end

  assign busy_out = (state_q != SHIFT_IDLE);
  assign sclk_out = sclk_q;
  assign mosi_out = shift_q[WORD_BITS-1];
  assign cs_b_out = cs_b_q;

endmodule

// [src/fsk_dac_tone_transmitter.sv]
// What this block does
// - Tones built from sine samples sent over SPI
// - Sample tick fixed at exactly one megahertz
// - Increment is table length over ticks per period
// - Truncate phase to index, send that entry
// - Add increment; above 4095 subtract 4095
// - Tick moves one buffered sample to SPI
// - Buffer end: completion event, swap, refill old
// - Bit timer counts cycles; 33-bit packet
// - Each bit selects mark or space increment
// - After 33 bits, stop samples, stay quiet
// - At 209 cycles restart counter and packet
// - All-ones packet default; zero selects all-zeros
// - Set transmit and amplifier enables before sending
// - Drive DAC-select output high
// - SPI words are ten bits long
`include "fsk_tx_map.svh"

module fsk_dac_tone_transmitter #(
  parameter int unsigned BIT_PERIOD_CYCLES =
    int'(64'(`FSK_BIT_PERIOD_NS) * 64'(`FSK_CLK_HZ) / 64'd1000000000),
  parameter int unsigned BUF_DEPTH = `FSK_BUF_DEPTH
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // Configuration
  input wire logic PACKET_SELECT_IN,
  // Front end control
  output logic TX_ENABLE_OUT,
  output logic POWER_AMP_ENABLE_OUT,
  output logic DAC_SELECT_OUT,
  // Serial sample link
  output logic SPI_SCLK_OUT,
  output logic SPI_MOSI_OUT,
  output logic SPI_CS_B_OUT,
  // Status
  output logic TX_ACTIVE_OUT,
  output logic CHIP_MARK_OUT,
  output fsk_tx_pkg::cycle_t CYCLE_COUNT_OUT,
  output logic ACTIVE_BUF_OUT,
  output logic BUF_DONE_OUT
);
  import fsk_tx_pkg::*;

  localparam int TICK_CYCLES = `FSK_CLK_HZ / `FSK_TICK_HZ;
  localparam int TICK_W = $clog2(TICK_CYCLES);
  localparam int BIT_W = $clog2(BIT_PERIOD_CYCLES);
  localparam int IDX_W = $clog2(BUF_DEPTH);
  localparam int PHASE_W = `FSK_PHASE_INT_BITS + `FSK_PHASE_FRAC;
  localparam phase_t INC_MARK = PHASE_W'(((64'(`FSK_TABLE_LEN) * 64'(`FSK_MARK_HZ))
    << `FSK_PHASE_FRAC) / 64'(`FSK_TICK_HZ));
  localparam phase_t INC_SPACE = PHASE_W'(((64'(`FSK_TABLE_LEN) * 64'(`FSK_SPACE_HZ))
    << `FSK_PHASE_FRAC) / 64'(`FSK_TICK_HZ));
  localparam phase_t WRAP = PHASE_W'(`FSK_WRAP_LIMIT) << `FSK_PHASE_FRAC;
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(BUF_DEPTH - 1);
  localparam logic [TICK_W-1:0] LAST_TICK = TICK_W'(TICK_CYCLES - 1);
  localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(BIT_PERIOD_CYCLES - 1);

  generate
    if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("BUF_DEPTH must be a power of two of at least 2");
    end
    if (BIT_PERIOD_CYCLES < 2 * TICK_CYCLES) begin : g_bad_period
      $error("BIT_PERIOD_CYCLES must span at least two sample ticks");
    end
    if (2 * `FSK_SPI_BITS + 2 > TICK_CYCLES) begin : g_bad_tick
      $error("A sample word must finish within one tick");
    end
    if (`FSK_FRAME_BITS > (1 << `FSK_CYCLE_BITS)) begin : g_bad_frame
      $error("Cycle counter too narrow for the frame");
    end
    if (`FSK_INDEX_BITS != `FSK_PHASE_INT_BITS - 1) begin : g_bad_index
      $error("Table index must be the phase integer part less its carry bit");
    end
  endgenerate

  // Approximate sine on 4096 points, centred on mid scale
  function automatic sample_t wave_lookup(input logic [`FSK_INDEX_BITS-1:0] index);
    logic [10:0] pos;
    logic [21:0] prod;
    logic [10:0] amp;
    sample_t mag;
    pos = index[10:0];
    prod = 22'(pos) * (22'd2048 - 22'(pos));
    amp = prod[21:11];
    mag = (amp > 11'(`FSK_AMP_MAX)) ? `FSK_AMP_MAX : sample_t'(amp);
    if (index[11]) begin
      wave_lookup = `FSK_SAMPLE_MID - mag;
    end else begin
      wave_lookup = `FSK_SAMPLE_MID + mag;
    end
  endfunction

  // Chip of the packet at a bit cycle; 1 means mark
  function automatic logic packet_chip(input logic sel, input cycle_t cyc);
    cycle_t pos;
    logic [`FSK_WORD_BITS-1:0] word;
    pos = cyc;
    if (pos >= cycle_t'(2 * `FSK_WORD_BITS)) begin
      pos = pos - cycle_t'(2 * `FSK_WORD_BITS);
    end else if (pos >= cycle_t'(`FSK_WORD_BITS)) begin
      pos = pos - cycle_t'(`FSK_WORD_BITS);
    end
    word = sel ? `FSK_CODE_ONE : `FSK_CODE_ZERO;
    // Quiet cycles read as space so the status pin never shows unknown
    packet_chip = 1'b0;
    if (cyc < cycle_t'(`FSK_PACKET_BITS)) begin
      packet_chip = word[`FSK_WORD_BITS - 1 - int'(pos)];
    end
  endfunction

  // True at the final entry of a bank
  function automatic logic last_entry(input logic [IDX_W-1:0] idx);
    last_entry = (idx == LAST_IDX);
  endfunction

  // Setup and timing state
  logic enable_q, enable_d;
  logic run_q, run_d;
  logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
  logic [BIT_W-1:0] bit_cnt_q, bit_cnt_d;
  cycle_t cycle_q, cycle_d;
  logic tick;
  logic bit_end;
  logic packet_end;
  logic in_packet;
  logic chip_mark;

  always_comb begin
    enable_d = 1'b1;
    run_d = enable_q;
    // Both timers start together, so every bit edge lands on a tick
    tick = run_q && (tick_cnt_q == LAST_TICK);
    bit_end = run_q && (bit_cnt_q == LAST_BIT);
    // The tick that closes the packet would start a word inside the quiet gap
    packet_end = bit_end && (cycle_q == cycle_t'(`FSK_PACKET_BITS - 1));
    tick_cnt_d = tick_cnt_q;
    bit_cnt_d = bit_cnt_q;
    cycle_d = cycle_q;
    if (run_q) begin
      tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
      bit_cnt_d = bit_end ? '0 : bit_cnt_q + 1'b1;
    end
    if (bit_end) begin
      if (cycle_q == cycle_t'(`FSK_FRAME_BITS - 1)) begin
        cycle_d = '0;
      end else begin
        cycle_d = cycle_q + 1'b1;
      end
    end
    in_packet = run_q && (cycle_q < cycle_t'(`FSK_PACKET_BITS));
    chip_mark = packet_chip(PACKET_SELECT_IN, cycle_q);
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      enable_q <= 1'b0;
      run_q <= 1'b0;
      tick_cnt_q <= '0;
      bit_cnt_q <= '0;
      cycle_q <= '0;
    end else begin
      enable_q <= enable_d;
      run_q <= run_d;
      tick_cnt_q <= tick_cnt_d;
      bit_cnt_q <= bit_cnt_d;
      cycle_q <= cycle_d;
    end
  end

  // Sample stream state
  phase_t phase_q, phase_d;
  sample_t buf_q [2][BUF_DEPTH];
  sample_t buf_d [2][BUF_DEPTH];
  logic [1:0] valid_q, valid_d;
  logic filling_q, filling_d;
  logic fill_bank_q, fill_bank_d;
  logic [IDX_W-1:0] fill_idx_q, fill_idx_d;
  logic active_q, active_d;
  logic [IDX_W-1:0] rd_idx_q, rd_idx_d;
  sample_t hold_q, hold_d;
  logic done_q, done_d;
  logic send;
  logic spi_busy;
  phase_t phase_increment;
  phase_t phase_sum;

  always_comb begin
    phase_d = phase_q;
    buf_d = buf_q;
    valid_d = valid_q;
    filling_d = filling_q;
    fill_bank_d = fill_bank_q;
    fill_idx_d = fill_idx_q;
    active_d = active_q;
    rd_idx_d = rd_idx_q;
    hold_d = hold_q;
    done_d = 1'b0;
    send = 1'b0;
    phase_increment = chip_mark ? INC_MARK : INC_SPACE;
    phase_sum = phase_q + phase_increment;
    if (!in_packet) begin
      // Quiet: everything parked so the next packet starts clean
      phase_d = '0;
      valid_d = '0;
      filling_d = 1'b0;
      fill_idx_d = '0;
      active_d = 1'b0;
      rd_idx_d = '0;
    end else begin
      // Mover: one sample per tick from the active bank
      if (tick && !packet_end && valid_q[active_q] && !spi_busy) begin
        hold_d = buf_q[active_q][rd_idx_q];
        send = 1'b1;
        rd_idx_d = rd_idx_q + 1'b1;
        if (last_entry(rd_idx_q)) begin
          valid_d[active_q] = 1'b0;
          active_d = ~active_q;
          done_d = 1'b1;
        end
      end
      // Filler: one table entry per clock into an empty bank
      if (filling_q) begin
        buf_d[fill_bank_q][fill_idx_q] =
          wave_lookup(phase_q[PHASE_W-2 -: `FSK_INDEX_BITS]);
        phase_d = (phase_sum > WRAP) ? phase_sum - WRAP : phase_sum;
        fill_idx_d = fill_idx_q + 1'b1;
        if (last_entry(fill_idx_q)) begin
          // Written after the mover's clear, so a set wins
          valid_d[fill_bank_q] = 1'b1;
          filling_d = 1'b0;
        end
      end else if (!valid_q[active_q]) begin
        filling_d = 1'b1;
        fill_bank_d = active_q;
        fill_idx_d = '0;
      end else if (!valid_q[~active_q]) begin
        filling_d = 1'b1;
        fill_bank_d = ~active_q;
        fill_idx_d = '0;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      phase_q <= '0;
      buf_q <= '{default: '0};
      valid_q <= '0;
      filling_q <= 1'b0;
      fill_bank_q <= 1'b0;
      fill_idx_q <= '0;
      active_q <= 1'b0;
      rd_idx_q <= '0;
      hold_q <= '0;
      done_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      buf_q <= buf_d;
      valid_q <= valid_d;
      filling_q <= filling_d;
      fill_bank_q <= fill_bank_d;
      fill_idx_q <= fill_idx_d;
      active_q <= active_d;
      rd_idx_q <= rd_idx_d;
      hold_q <= hold_d;
      done_q <= done_d;
    end
  end

  // Holding register feeds the ten-bit shifter one cycle after the tick
  logic send_q;

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      send_q <= 1'b0;
    end else begin
      send_q <= send;
    end
  end

  dac_sample_shifter u_shifter (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .start_in(send_q),
    .data_in(hold_q),
    .busy_out(spi_busy),
    .sclk_out(SPI_SCLK_OUT),
    .mosi_out(SPI_MOSI_OUT),
    .cs_b_out(SPI_CS_B_OUT)
  );

  assign TX_ENABLE_OUT = enable_q;
  assign POWER_AMP_ENABLE_OUT = enable_q;
  assign DAC_SELECT_OUT = enable_q;
  assign TX_ACTIVE_OUT = in_packet;
  assign CHIP_MARK_OUT = chip_mark;
  assign CYCLE_COUNT_OUT = cycle_q;
  assign ACTIVE_BUF_OUT = active_q;
  assign BUF_DONE_OUT = done_q;

endmodule

// [tb/fsk_tx_assertions.sv]
module fsk_tx_checker #(
  parameter int unsigned BIT_PERIOD_CYCLES = 256000,
  parameter int unsigned BUF_DEPTH = 16
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // Watched ports
  input wire logic PACKET_SELECT_IN,
  input wire logic TX_ENABLE_OUT,
  input wire logic POWER_AMP_ENABLE_OUT,
  input wire logic DAC_SELECT_OUT,
  input wire logic SPI_SCLK_OUT,
  input wire logic SPI_MOSI_OUT,
  input wire logic SPI_CS_B_OUT,
  input wire logic TX_ACTIVE_OUT,
  input wire logic CHIP_MARK_OUT,
  input wire fsk_tx_pkg::cycle_t CYCLE_COUNT_OUT,
  input wire logic ACTIVE_BUF_OUT,
  input wire logic BUF_DONE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  import fsk_tx_pkg::*;
  localparam logic [10:0] W1 = 11'h0ED;
  logic [4:0] low_q, low_d;
  logic [7:0] gap_q, gap_d;
  logic cs_q;
  logic [3:0] idx;
  assign idx = 4'(CYCLE_COUNT_OUT % 8'd11);
  always_comb begin
    low_d = SPI_CS_B_OUT ? 5'h00 : low_q + 5'h01;
    gap_d = (cs_q && !SPI_CS_B_OUT) ? 8'h00 : (gap_q == 8'hFF ? gap_q : gap_q + 8'h01);
  end
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      low_q <= 5'h00;
      gap_q <= 8'hFF;
      cs_q <= 1'b1;
    end else begin
      low_q <= low_d;
      gap_q <= gap_d;
      cs_q <= SPI_CS_B_OUT;
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  AST_ENABLES: assert property ($rose(TX_ACTIVE_OUT) |->
    $past(TX_ENABLE_OUT) && $past(POWER_AMP_ENABLE_OUT)) else $error("enables late");
  AST_DAC_SEL: assert property (!SPI_CS_B_OUT |-> DAC_SELECT_OUT)
    else $error("word without DAC select");
  AST_QUIET: assert property ((!TX_ACTIVE_OUT)[*3] ##0 SPI_CS_B_OUT |=> SPI_CS_B_OUT)
    else $error("word in quiet");
  AST_CS_LEN: assert property ($rose(SPI_CS_B_OUT) |-> low_q == 5'd20)
    else $error("word length wrong");
  AST_TICK: assert property (cs_q && !SPI_CS_B_OUT |-> gap_q == 8'd49 || gap_q == 8'hFF)
    else $error("tick spacing wrong");
  AST_SWAP: assert property (BUF_DONE_OUT |-> ACTIVE_BUF_OUT != $past(ACTIVE_BUF_OUT))
    else $error("no buffer swap");
  AST_CYCLE: assert property ($changed(CYCLE_COUNT_OUT) |->
    CYCLE_COUNT_OUT == $past(CYCLE_COUNT_OUT) + 8'd1 ||
    ($past(CYCLE_COUNT_OUT) == 8'd208 && CYCLE_COUNT_OUT == 8'd0)) else $error("bad count step");
  AST_ACTIVE: assert property (TX_ACTIVE_OUT |-> CYCLE_COUNT_OUT < 8'd33)
    else $error("active past packet");
  AST_CHIP: assert property (TX_ACTIVE_OUT |->
    CHIP_MARK_OUT == (W1[4'd10 - idx] ~^ PACKET_SELECT_IN)) else $error("wrong chip");
  cover property ($rose(BUF_DONE_OUT));
  cover property ($fell(TX_ACTIVE_OUT));
  cover property ($past(CYCLE_COUNT_OUT) == 8'd208 && CYCLE_COUNT_OUT == 8'd0);
endmodule

bind fsk_dac_tone_transmitter fsk_tx_checker #(
  .BIT_PERIOD_CYCLES(BIT_PERIOD_CYCLES), .BUF_DEPTH(BUF_DEPTH)) chk (.CLK_IN, .RST_B_IN,
  .PACKET_SELECT_IN, .TX_ENABLE_OUT, .POWER_AMP_ENABLE_OUT, .DAC_SELECT_OUT, .SPI_SCLK_OUT,
  .SPI_MOSI_OUT, .SPI_CS_B_OUT, .TX_ACTIVE_OUT, .CHIP_MARK_OUT, .CYCLE_COUNT_OUT,
  .ACTIVE_BUF_OUT, .BUF_DONE_OUT);

// [tb/dac_front_model.sv]
// Front end DAC input: takes 10-bit words, top bit first, on rising serial clock
module dac_front_model (
  // Serial pins
  input wire logic sclk_in,
  input wire logic mosi_in,
  input wire logic cs_b_in,
  input wire logic dac_sel_in,
  // Observed words
  output int words_out,
  output int bad_out,
  output logic [9:0] last_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] sh = 10'h000;
  int n = 0;
  always @(posedge sclk_in or posedge cs_b_in) begin
    if (cs_b_in) begin
      if (n == 10 && dac_sel_in) begin
        words_out <= words_out + 1;
        last_out <= sh;
      end else if (n != 0) begin
        bad_out <= bad_out + 1;
      end
      n <= 0;
    end else begin
      sh <= {sh[8:0], mosi_in};
      n <= n + 1;
    end
  end
endmodule

// [tb/fsk_dac_tone_transmitter_test.sv]
module fsk_dac_tone_transmitter_test;
  timeunit 1ns;
  timeprecision 1ps;
  import fsk_tx_pkg::*;
  localparam logic [10:0] W1 = 11'h0ED;
  logic clk, rst_b, pkt_sel, tx_en, pa_en, dac_sel, sclk, mosi, cs_b, active, mark, abuf, done;
  cycle_t cyc;
  logic [9:0] last;
  int words, bad, err_total, total_checks, done_cnt, ticks, w0, d0;
  fsk_dac_tone_transmitter #(.BIT_PERIOD_CYCLES(200), .BUF_DEPTH(16)) dut (
    .CLK_IN(clk), .RST_B_IN(rst_b), .PACKET_SELECT_IN(pkt_sel), .TX_ENABLE_OUT(tx_en),
    .POWER_AMP_ENABLE_OUT(pa_en), .DAC_SELECT_OUT(dac_sel), .SPI_SCLK_OUT(sclk),
    .SPI_MOSI_OUT(mosi), .SPI_CS_B_OUT(cs_b), .TX_ACTIVE_OUT(active), .CHIP_MARK_OUT(mark),
    .CYCLE_COUNT_OUT(cyc), .ACTIVE_BUF_OUT(abuf), .BUF_DONE_OUT(done));
  dac_front_model front (.sclk_in(sclk), .mosi_in(mosi), .cs_b_in(cs_b),
    .dac_sel_in(dac_sel), .words_out(words), .bad_out(bad), .last_out(last));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic set_packet(input logic v);
    @(posedge clk);
    #2 pkt_sel = v;
  endtask
  // Go to the middle of bit cycle n
  task automatic wait_cyc(input int n);
    for (int k = 0; k < 45000 && cyc !== 8'(n); k++) @(posedge clk);
    repeat (100) @(posedge clk);
    #2;
  endtask
  task automatic wait_word;
    w0 = words;
    for (int k = 0; k < 300 && words == w0; k++) @(posedge clk);
    #2;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (done === 1'b1) done_cnt++;
    ticks++;
    if (ticks == 50000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    pkt_sel = 1'b1;
    rst_b = 1'b0;
    repeat (10) @(posedge clk);
    #2 rst_b = 1'b1;
    repeat (2) @(posedge clk);
    #2 check(16'(tx_en), 16'h0001);
    check(16'(pa_en), 16'h0001);
    check(16'(dac_sel), 16'h0001);
    wait_word();
    check(16'(last), 16'h0200);
    for (int c = 0; c < 33; c++) begin
      if (c == 11) set_packet(1'b0);
      wait_cyc(c);
      check(16'(mark), 16'({W1[10 - c % 11] ~^ pkt_sel}));
      check(16'(active), 16'h0001);
      if (c == 5) begin
        w0 = words;
        d0 = done_cnt;
      end
      if (c == 13) begin
        check(16'(words - w0), 16'h0020);
        check(16'(done_cnt - d0), 16'h0002);
      end
    end
    wait_cyc(34);
    check(16'(active), 16'h0000);
    w0 = words;
    wait_cyc(200);
    check(16'(words - w0), 16'h0000);
    check(16'(cs_b), 16'h0001);
    for (int k = 0; k < 45000 && cyc !== 8'h00; k++) @(posedge clk);
    wait_word();
    check(16'(last), 16'h0200);
    check(16'(active), 16'h0001);
    wait_word();
    check(16'(last), 16'h038C);
    check(16'(bad), 16'h0000);
    complete_run();
  end
endmodule
